// *** rtl/ser_core.sv ***
// status byte, standard event register, enables, error queue and output queue
// assumes commands arrive already decoded on MCLK_I; local key is an async pin
//
// What this block does
// - status bits 0 and 1 always read zero
// - bit 2 set while error queue nonempty
// - bit 3 summarises enabled questionable events
// - bit 4 set while output queue holds response
// - bit 5 summarises enabled standard events
// - bit 6 signals service request, read by poll
// - bit 7 summarises operation events with enable
// - poll and status query return current bits
// - operation complete set once pending work ends
// - event bit1 zero; query, device errors set 2,3
// - execution error sets 4, command error 5
// - local key press sets event bit 6
// - power-up sets event bit 7
// - event register query returns then clears
// - event enable mask writable and readable, aligned
// - summary is OR of status AND enable
// - operation enable exists; operation status stays zero
// - service request mask selects requesting status bits
// - new message clears the output queue
// - errors queued first-in first-out, query pops oldest
// - overflow stores -350, blocks until read/cleared
// - queued codes set matching event bits
// - event bits latch on rising condition
// - latched event bit holds until read or cleared
module ser_core
   import ser_pkg::*;
(
   // clock and reset
   input wire logic MCLK_I,
   input wire logic RST_I,
   // decoded host commands and message framing
   input wire ser_cmd_t CMD_I,
   input wire logic MSG_START_I,
   input wire logic OQ_READ_I,
   input wire logic SPOLL_I,
   // event sources
   input wire ser_err_t ERR_I,
   input wire logic OPS_BUSY_I,
   input wire logic LOCAL_KEY_I,
   input wire logic [15:0] QUESTIONABLE_SUMMARY_BIT_COND_I,
   // status outputs
   output logic [7:0] STB_O,
   output logic SRQ_O,
   output ser_rsp_t RSP_O,
   output ser_poll_t POLL_O
);

   ser_state_t q;
   ser_state_t s;
   logic [7:0] esr_set;
   logic [7:0] esr_clr;
   logic [15:0] qst_set;
   logic [15:0] qst_clr;
   logic [7:0] stb_n;
   logic key_rise;
   logic do_pop;
   logic do_cls;

   function automatic logic [7:0] code_to_esr(input logic signed [15:0] code);
      logic [7:0] m;
      m = 8'h00;
      if (code == ERR_CMD) begin
         m[ESR_PARSE] = 1'b1;
      end else if (code <= ERR_EXEC_HI && code >= ERR_EXEC_LO) begin
         m[ESR_EXEC] = 1'b1;
      end else if (code == ERR_HW || (code <= ERR_DEV_HI && code >= ERR_OVF)) begin
         m[ESR_DEV] = 1'b1;
      end else if (code <= ERR_QRY_HI && code >= ERR_QRY_LO) begin
         m[ESR_QERR] = 1'b1;
      end
      return m;
   endfunction : code_to_esr

   always_comb begin
      s = q;
      esr_set = 8'h00;
      esr_clr = 8'h00;
      qst_set = 16'h0000;
      qst_clr = 16'h0000;
      stb_n = 8'h00;
      do_pop = 1'b0;
      do_cls = 1'b0;
      s.poll = '0;

      // local key pin synchroniser and press detect
      s.key_s1 = LOCAL_KEY_I;
      s.key_s2 = q.key_s1;
      s.key_s3 = q.key_s2;
      key_rise = q.key_s2 & ~q.key_s3;
      if (key_rise) begin
         esr_set[ESR_KEY] = 1'b1;
      end

      // questionable conditions latch on rising edge only
      s.qcond_prev = QUESTIONABLE_SUMMARY_BIT_COND_I;
      qst_set = QUESTIONABLE_SUMMARY_BIT_COND_I & ~q.qcond_prev;

      // operation-complete wait
      case (q.done_st)
         DONE_IDLE: begin
            if (CMD_I.valid && CMD_I.op == CMD_DONE) begin
               s.done_st = DONE_WAIT;
            end
         end
         DONE_WAIT: begin
            if (!OPS_BUSY_I) begin
               esr_set[ESR_DONE] = 1'b1;
               s.done_st = DONE_IDLE;
            end
         end
         default: begin
            s.done_st = DONE_IDLE;
         end
      endcase

      // output queue cleared by a new message or a host read
      if (MSG_START_I || OQ_READ_I) begin
         s.msg_avail = 1'b0;
      end

      if (CMD_I.valid) begin
         case (CMD_I.op)
            CMD_STB_Q: begin
               s.oq_data = {8'h00, q.stb};
               s.msg_avail = 1'b1;
            end
            CMD_ESR_Q: begin
               s.oq_data = {8'h00, q.esr};
               s.msg_avail = 1'b1;
               esr_clr = 8'hFF;
            end
            CMD_ESE_W: begin
               s.ese = CMD_I.data[7:0];
            end
            CMD_ESE_Q: begin
               s.oq_data = {8'h00, q.ese};
               s.msg_avail = 1'b1;
            end
            CMD_SRE_W: begin
               s.sre = CMD_I.data[7:0] & STB_SREQ_MASK;
            end
            CMD_SRE_Q: begin
               s.oq_data = {8'h00, q.sre};
               s.msg_avail = 1'b1;
            end
            CMD_ERR_Q: begin
               s.oq_data = (q.ecnt == 4'h0) ? ERR_NONE : q.eq[0];
               s.msg_avail = 1'b1;
               do_pop = (q.ecnt != 4'h0);
            end
            CMD_CLS: begin
               do_cls = 1'b1;
               esr_clr = 8'hFF;
               qst_clr = 16'hFFFF;
            end
            CMD_QEN_W: begin
               s.qst_en = CMD_I.data;
            end
            CMD_QEN_Q: begin
               s.oq_data = q.qst_en;
               s.msg_avail = 1'b1;
            end
            CMD_QEV_Q: begin
               s.oq_data = q.qst_ev;
               s.msg_avail = 1'b1;
               qst_clr = 16'hFFFF;
            end
            CMD_OEN_W: begin
               s.opst_en = CMD_I.data;
            end
            CMD_OEN_Q: begin
               s.oq_data = q.opst_en;
               s.msg_avail = 1'b1;
            end
            CMD_OEV_Q: begin
               s.oq_data = 16'h0000;
               s.msg_avail = 1'b1;
            end
            default: begin
            end
         endcase
      end

      // error queue: pop or clear first, then push
      if (do_cls) begin
         s.ecnt = 4'h0;
      end else if (do_pop) begin
         for (int i = 0; i < QDEPTH - 1; i++) begin
            s.eq[i] = q.eq[i+1];
         end
         s.eq[QDEPTH-1] = 16'h0000;
         s.ecnt = q.ecnt - 4'h1;
      end
      if (ERR_I.valid && ERR_I.code != ERR_NONE) begin
         if (s.ecnt < QLAST) begin
            s.eq[s.ecnt[2:0]] = ERR_I.code;
            s.ecnt = s.ecnt + 4'h1;
            esr_set = esr_set | code_to_esr(ERR_I.code);
         end else if (s.ecnt == QLAST) begin
            s.eq[QLAST[2:0]] = ERR_OVF;
            s.ecnt = QFULL;
            esr_set = esr_set | code_to_esr(ERR_OVF);
         end
      end

      // event registers: set wins over clear, held until read or cleared
      s.esr = ((q.esr & ~esr_clr) | esr_set) & ESR_WR_MASK;
      s.qst_ev = (q.qst_ev & ~qst_clr) | qst_set;

      // summary status byte from next state
      stb_n[STB_ERRQ] = (s.ecnt != 4'h0);
      stb_n[STB_QSUM] = |(s.qst_ev & s.qst_en);
      stb_n[STB_MSG] = s.msg_avail;
      stb_n[STB_ESUM] = |(s.esr & s.ese);
      stb_n[STB_OSUM] = |(16'h0000 & s.opst_en);
      stb_n[STB_SREQ] = |(stb_n & s.sre & STB_SREQ_MASK);
      s.stb = stb_n;
      s.srq = stb_n[STB_SREQ];

      if (SPOLL_I) begin
         s.poll.valid = 1'b1;
         s.poll.data = q.stb;
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         q <= '0;
         q.esr <= ESR_RESET;
         q.done_st <= DONE_IDLE;
      end else begin
         q <= s;
      end
   end

   assign STB_O = q.stb;
   assign SRQ_O = q.srq;
   assign RSP_O = '{valid: q.msg_avail, data: q.oq_data};
   assign POLL_O = q.poll;

   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (RST_I);

   stb_low_zero_a: assert property (STB_O[1:0] == 2'b00)
      else $error("status low bits not zero");
   err_pending_a: assert property (STB_O[STB_ERRQ] == (q.ecnt != 4'h0))
      else $error("error pending bit wrong");
   msg_bit_a: assert property (STB_O[STB_MSG] == RSP_O.valid)
      else $error("message available bit wrong");
   event_sum_a: assert property (STB_O[STB_ESUM] == |(q.esr & q.ese))
      else $error("event summary bit wrong");
   questionable_summary_bit_sum_a: assert property (STB_O[STB_QSUM] == |(q.qst_ev & q.qst_en))
      else $error("questionable summary bit wrong");
   srq_gate_a: assert property (SRQ_O == |(STB_O & q.sre & STB_SREQ_MASK))
      else $error("service request gating wrong");
   opsum_zero_a: assert property (!STB_O[STB_OSUM])
      else $error("operation summary not zero");
   esr_bit1_a: assert property (!q.esr[1])
      else $error("event bit 1 set");
   done_set_a: assert property (q.done_st == DONE_WAIT && !OPS_BUSY_I |=> q.esr[ESR_DONE])
      else $error("operation complete not set");
   poll_data_a: assert property (SPOLL_I |=> POLL_O.valid && POLL_O.data == $past(STB_O))
      else $error("serial poll answer wrong");
   esr_read_a: assert property (CMD_I.valid && CMD_I.op == CMD_ESR_Q |=>
      RSP_O.valid && RSP_O.data == {8'h00, $past(q.esr)})
      else $error("event query data wrong");
   err_empty_a: assert property (CMD_I.valid && CMD_I.op == CMD_ERR_Q && q.ecnt == 4'h0
      && !ERR_I.valid |=> RSP_O.data == 16'h0000 && q.ecnt == 4'h0)
      else $error("empty error query wrong");
   fifo_head_a: assert property (CMD_I.valid && CMD_I.op == CMD_ERR_Q && q.ecnt != 4'h0
      |=> RSP_O.data == $past(q.eq[0]))
      else $error("error queue order wrong");
   ovf_hold_a: assert property (q.ecnt == QFULL && !(CMD_I.valid && (CMD_I.op == CMD_ERR_Q
      || CMD_I.op == CMD_CLS)) |=> q.ecnt == QFULL && q.eq[QLAST[2:0]] == ERR_OVF)
      else $error("overflow not held");
   msg_clear_a: assert property (MSG_START_I && !CMD_I.valid |=> !RSP_O.valid)
      else $error("output queue not cleared");

endmodule : ser_core

// *** rtl/ser_pkg.sv ***
// constants and carrier types for the status and event reporting block
// assumes one clock domain and a parser that decodes host messages into commands
package ser_pkg;

   // summary status byte bit positions
   localparam int STB_ERRQ = 2;
   localparam int STB_QSUM = 3;
   localparam int STB_MSG = 4;
   localparam int STB_ESUM = 5;
   localparam int STB_SREQ = 6;
   localparam int STB_OSUM = 7;
   localparam logic [7:0] STB_SREQ_MASK = 8'hBF;

   // standard event register bit positions
   localparam int ESR_DONE = 0;
   localparam int ESR_QERR = 2;
   localparam int ESR_DEV = 3;
   localparam int ESR_EXEC = 4;
   localparam int ESR_PARSE = 5;
   localparam int ESR_KEY = 6;
   localparam int ESR_PWR = 7;
   localparam logic [7:0] ESR_RESET = 8'h80;
   localparam logic [7:0] ESR_WR_MASK = 8'hFD;

   // error queue
   localparam int QDEPTH = 8;
   localparam logic [3:0] QFULL = 4'h8;
   localparam logic [3:0] QLAST = 4'h7;

   // error codes, 16-bit two's complement
   localparam logic signed [15:0] ERR_NONE = 16'h0000;
   localparam logic signed [15:0] ERR_CMD = 16'hFF9C;     // -100
   localparam logic signed [15:0] ERR_EXEC_HI = 16'hFF38;  // -200
   localparam logic signed [15:0] ERR_EXEC_LO = 16'hFF22;  // -222
   localparam logic signed [15:0] ERR_HW = 16'hFF10;      // -240
   localparam logic signed [15:0] ERR_DEV_HI = 16'hFED4;  // -300
   localparam logic signed [15:0] ERR_OVF = 16'hFEA2;     // -350
   localparam logic signed [15:0] ERR_QRY_HI = 16'hFE66;  // -410
   localparam logic signed [15:0] ERR_QRY_LO = 16'hFE52;  // -430

   typedef enum logic [3:0] {
      CMD_NONE = 4'h0,
      CMD_STB_Q = 4'h1,
      CMD_ESR_Q = 4'h2,
      CMD_ESE_W = 4'h3,
      CMD_ESE_Q = 4'h4,
      CMD_SRE_W = 4'h5,
      CMD_SRE_Q = 4'h6,
      CMD_ERR_Q = 4'h7,
      CMD_DONE = 4'h8,
      CMD_CLS = 4'h9,
      CMD_QEN_W = 4'hA,
      CMD_QEN_Q = 4'hB,
      CMD_QEV_Q = 4'hC,
      CMD_OEN_W = 4'hD,
      CMD_OEN_Q = 4'hE,
      CMD_OEV_Q = 4'hF
   } ser_cmd_op_t;

   typedef enum logic [1:0] {
      DONE_IDLE = 2'b01,
      DONE_WAIT = 2'b10
   } ser_done_st_t;

   typedef struct packed {
      logic valid;
      ser_cmd_op_t op;
      logic [15:0] data;
   } ser_cmd_t;

   typedef struct packed {
      logic valid;
      logic signed [15:0] code;
   } ser_err_t;

   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } ser_rsp_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } ser_poll_t;

   typedef struct packed {
      logic key_s1;
      logic key_s2;
      logic key_s3;
      logic [15:0] qcond_prev;
      logic [15:0] qst_ev;
      logic [15:0] qst_en;
      logic [15:0] opst_en;
      logic [7:0] esr;
      logic [7:0] ese;
      logic [7:0] sre;
      logic [QDEPTH-1:0][15:0] eq;
      logic [3:0] ecnt;
      logic msg_avail;
      logic [15:0] oq_data;
      ser_done_st_t done_st;
      logic [7:0] stb;
      logic srq;
      ser_poll_t poll;
   } ser_state_t;

endpackage : ser_pkg

// *** bench/ser_host.sv ***
// host model: issues decoded commands, reads each response, polls
// assumes the core answers a query on RSP_O and a poll on POLL_O
module ser_host
   import ser_pkg::*;
(
   // clock
   input wire logic clk_i,
   // answers from the core
   input wire ser_rsp_t rsp_i,
   input wire ser_poll_t poll_i,
   // requests to the core
   output ser_cmd_t cmd_o,
   output logic msg_start_o,
   output logic oq_read_o,
   output logic spoll_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cmd_o = '0;
      msg_start_o = 1'b0;
      oq_read_o = 1'b0;
      spoll_o = 1'b0;
   end
   task automatic send(input ser_cmd_op_t op, input logic [15:0] d);
      @(negedge clk_i);
      cmd_o = '{1'b1, op, d};
      @(negedge clk_i);
      cmd_o = '0;
   endtask : send
   task automatic new_msg();
      @(negedge clk_i);
      msg_start_o = 1'b1;
      @(negedge clk_i);
      msg_start_o = 1'b0;
   endtask : new_msg
   task automatic query(input ser_cmd_op_t op, output logic [15:0] d);
      int n;
      send(op, 16'h0000);
      for (n = 0; n < 8 && rsp_i.valid !== 1'b1; n++) @(negedge clk_i);
      if (n == 8) tb_top.timeout_hit();
      d = rsp_i.data;
      // response taken before any further message
      oq_read_o = 1'b1;
      @(negedge clk_i);
      oq_read_o = 1'b0;
   endtask : query
   task automatic poll(output logic [7:0] d);
      int n;
      @(negedge clk_i);
      spoll_o = 1'b1;
      @(negedge clk_i);
      spoll_o = 1'b0;
      for (n = 0; n < 8 && poll_i.valid !== 1'b1; n++) @(negedge clk_i);
      if (n == 8) tb_top.timeout_hit();
      d = poll_i.data;
   endtask : poll
endmodule : ser_host

// *** bench/tb_top.sv ***
// bench for the status and event reporting core
// assumes the host model in ser_host.sv drives the command side
module tb_top
   import ser_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [15:0] code;
      logic [7:0] esr;
   } ser_row_t;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   ser_err_t err = '0;
   logic busy = 1'b0;
   logic key = 1'b0;
   logic [15:0] questionable_summary_bit = 16'h0000;
   logic [7:0] stb;
   logic srq;
   ser_rsp_t rsp;
   ser_poll_t poll;
   ser_cmd_t cmd;
   logic msg, oqr, sp;
   logic [7:0] pd;
   int bad_count = 0;
   int checks_done = 0;
   ser_row_t rows [8] = '{'{16'hFF9C, 8'h20}, '{16'hFF38, 8'h10}, '{16'hFF22, 8'h10},
      '{16'hFF10, 8'h08}, '{16'hFED4, 8'h08}, '{16'hFEA2, 8'h08}, '{16'hFE66, 8'h04},
      '{16'hFE52, 8'h04}};
   always #2.5 mclk = ~mclk;
   ser_core i_ser_core (.MCLK_I(mclk), .RST_I(rst), .CMD_I(cmd), .MSG_START_I(msg),
      .OQ_READ_I(oqr), .SPOLL_I(sp), .ERR_I(err), .OPS_BUSY_I(busy), .LOCAL_KEY_I(key),
      .QUESTIONABLE_SUMMARY_BIT_COND_I(questionable_summary_bit), .STB_O(stb), .SRQ_O(srq), .RSP_O(rsp), .POLL_O(poll));
   ser_host i_ser_host (.clk_i(mclk), .rsp_i(rsp), .poll_i(poll), .cmd_o(cmd),
      .msg_start_o(msg), .oq_read_o(oqr), .spoll_o(sp));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude
   task automatic timeout_hit();
      bad_count++;
      $display("unexpected at %0t: wait ran out", $time);
      conclude();
   endtask : timeout_hit
   task automatic push(input logic [15:0] c);
      @(negedge mclk);
      err = '{1'b1, c};
      @(negedge mclk);
      err = '0;
   endtask : push
   task automatic qry(input ser_cmd_op_t op, input logic [15:0] exp);
      logic [15:0] d;
      i_ser_host.query(op, d);
      chk(d, exp);
   endtask : qry
   task automatic stbchk(input logic [7:0] exp);
      repeat (2) @(negedge mclk);
      chk({8'h00, stb}, {8'h00, exp});
   endtask : stbchk
   task automatic reset_core();
      rst = 1'b1;
      repeat (6) @(negedge mclk);
      rst = 1'b0;
   endtask : reset_core
   initial begin
      reset_core();
      stbchk(8'h00);
      qry(CMD_ESR_Q, 16'h0080);
      qry(CMD_ESR_Q, 16'h0000);
      qry(CMD_ERR_Q, 16'h0000);
      $display("test reset done");
      foreach (rows[i]) begin
         push(rows[i].code);
         stbchk(8'h04);
         qry(CMD_ERR_Q, rows[i].code);
         qry(CMD_ESR_Q, {8'h00, rows[i].esr});
      end
      $display("test codes done");
      i_ser_host.send(CMD_ESE_W, 16'h0020);
      qry(CMD_ESE_Q, 16'h0020);
      push(16'hFF9C);
      qry(CMD_ERR_Q, 16'hFF9C);
      stbchk(8'h20);
      i_ser_host.send(CMD_SRE_W, 16'h0060);
      qry(CMD_SRE_Q, 16'h0020);
      stbchk(8'h60);
      chk({15'h0, srq}, 16'h0001);
      qry(CMD_STB_Q, 16'h0060);
      i_ser_host.poll(pd);
      chk({8'h00, pd}, 16'h0060);
      qry(CMD_ESR_Q, 16'h0020);
      stbchk(8'h00);
      $display("test enables done");
      i_ser_host.send(CMD_ESE_Q, 16'h0000);
      stbchk(8'h10);
      i_ser_host.new_msg();
      stbchk(8'h00);
      i_ser_host.send(CMD_OEN_W, 16'hFFFF);
      qry(CMD_OEN_Q, 16'hFFFF);
      qry(CMD_OEV_Q, 16'h0000);
      stbchk(8'h00);
      i_ser_host.send(CMD_QEN_W, 16'h0001);
      qry(CMD_QEN_Q, 16'h0001);
      questionable_summary_bit = 16'h0001;
      stbchk(8'h08);
      questionable_summary_bit = 16'h0000;
      stbchk(8'h08);
      qry(CMD_QEV_Q, 16'h0001);
      stbchk(8'h00);
      $display("test queues done");
      busy = 1'b1;
      i_ser_host.send(CMD_DONE, 16'h0000);
      repeat (4) @(negedge mclk);
      qry(CMD_ESR_Q, 16'h0000);
      busy = 1'b0;
      repeat (3) @(negedge mclk);
      qry(CMD_ESR_Q, 16'h0001);
      key = 1'b1;
      repeat (8) @(negedge mclk);
      key = 1'b0;
      repeat (3) @(negedge mclk);
      qry(CMD_ESR_Q, 16'h0040);
      $display("test events done");
      repeat (9) push(16'hFF9C);
      repeat (7) qry(CMD_ERR_Q, 16'hFF9C);
      qry(CMD_ERR_Q, 16'hFEA2);
      qry(CMD_ERR_Q, 16'h0000);
      qry(CMD_ESR_Q, 16'h0028);
      push(16'hFF38);
      i_ser_host.send(CMD_CLS, 16'h0000);
      stbchk(8'h00);
      qry(CMD_ERR_Q, 16'h0000);
      reset_core();
      qry(CMD_ESR_Q, 16'h0080);
      $display("test overflow done");
      conclude();
   end
endmodule : tb_top
